/* File: hw/card_uart_config_two_defines.vh */
// Register offsets, field positions, reset values and timing counts for the card configuration block
`ifndef CARD_UART_CONFIG_TWO_DEFINES_VH
`define CARD_UART_CONFIG_TWO_DEFINES_VH

// ----------------------------------------------------------------------------
// Register offsets (chosen)
// ----------------------------------------------------------------------------
`define ADDR_CONFIG_TWO     4'h0
`define ADDR_CARD_SELECT    4'h1
`define ADDR_HW_STATUS      4'h2
`define ADDR_UART_STATUS    4'h3
`define ADDR_MIXED_STATUS   4'h4
`define ADDR_CLOCK_CONFIG   4'h5
`define ADDR_RX_DATA        4'h6
`define ADDR_TX_DATA        4'h7
`define ADDR_ETU_DIVIDER    4'h8

// ----------------------------------------------------------------------------
// Field positions in card_uart_config_two
// ----------------------------------------------------------------------------
`define BIT_UNUSED_TOP      7
`define BIT_BUF_IRQ_DIS     6
`define BIT_AUX_IRQ_DIS     5
`define BIT_POWER_DOWN      4
`define BIT_SYNC_CARD       3
`define BIT_AUTO_CONV_OFF   2
`define BIT_ETU_HALVING     1
`define BIT_PRESCALE_SEL    0

// Hardware status bits
`define HSR_AUX_LATCH       0
`define HSR_SUP_LATCH       1
`define HSR_PRES1_CHG       2
`define HSR_PRES2_CHG       3

// Clock configuration bits
`define CCR_SYNC_CLOCK      0
`define CCR_CLK_IS_XTAL     1

// ----------------------------------------------------------------------------
// Reset values and constants
// ----------------------------------------------------------------------------
`define CONFIG_TWO_RESET    8'h00
`define CONFIG_WRITE_MASK   8'h7F
`define PRESCALE_HI         6'h20
`define PRESCALE_LO         6'h1F
`define NUM_CARDS           3

// ----------------------------------------------------------------------------
// Timing
// ----------------------------------------------------------------------------
`define WAKE_WAIT_MS        5
`define CLK_MHZ             125
`define WAKE_WAIT_CYCLES    (`WAKE_WAIT_MS * 1000 * `CLK_MHZ)

`endif

/* File: hw/card_config_store.v */
// Per-slot storage of the configuration register, registered read data
`timescale 1ns/1ps
`default_nettype none
`include "card_uart_config_two_defines.vh"

module card_config_store (
  input  wire       clk,
  input  wire       rst,
  input  wire       wr_en,
  input  wire [1:0] wr_slot,
  input  wire [7:0] wr_data,
  input  wire [1:0] rd_slot,
  output reg  [7:0] rd_data
);

  reg [7:0] mem_q [0:`NUM_CARDS-1];

  genvar g;
  generate
    for (g = 0; g < `NUM_CARDS; g = g + 1) begin : slot
      always @(posedge clk) begin
        if (rst) begin
          mem_q[g] <= `CONFIG_TWO_RESET;
        end else if (wr_en && wr_slot == g) begin
          mem_q[g] <= wr_data & `CONFIG_WRITE_MASK;
        end
      end
    end
  endgenerate

  always @(posedge clk) begin
    if (rst) begin
      rd_data <= `CONFIG_TWO_RESET;
    end else if (rd_slot < `NUM_CARDS) begin
      rd_data <= mem_q[rd_slot];
    end else begin
      rd_data <= 8'h00;
    end
  end

endmodule
`default_nettype wire

/* File: hw/card_uart_config_two.v */
// Card configuration register two with power-down, wake-up, masking and sync-card bypass
//
// The address-and-strobe port and the register offsets were decided locally.
`timescale 1ns/1ps
`default_nettype none
`include "card_uart_config_two_defines.vh"

module card_uart_config_two #(
  parameter WAKE_WAIT = `WAKE_WAIT_CYCLES
) (
  input  wire       clk,
  input  wire       rst,
  input  wire [3:0] addr,
  input  wire [7:0] wdata,
  input  wire       wr,
  input  wire       rd,
  output reg  [7:0] rdata,
  input  wire       cs_n,
  input  wire       aux_interrupt_pin,
  input  wire       card1_present,
  input  wire       card2_present,
  input  wire       supervisor_event,
  input  wire       uart_rx_done,
  input  wire       uart_tx_done,
  input  wire       buffer_empty_full_flag,
  input  wire [7:0] uart_flags,
  input  wire       uart_io_out,
  input  wire       uart_io_oe,
  input  wire       detected_convention,
  input  wire       sw_convention,
  input  wire       gen_card_clk,
  input  wire       card_io_in,
  output wire       card_io_out,
  output wire       card_io_oe,
  output wire       card_clk,
  output wire       osc_enable,
  output wire       irq_n,
  output reg  [1:0] card_select,
  output wire       convention,
  output wire [13:0] etu_cycles
);

  // --------------------------------------------------------------------------
  // Pin synchronisers
  // --------------------------------------------------------------------------
  // Only the second stage feeds logic; prev_q is the edge reference
  reg [3:0] sync1_q;
  reg [3:0] sync2_q;
  reg [3:0] prev_q;
  always @(posedge clk) begin
    if (rst) begin
      sync1_q <= 4'h0;
      sync2_q <= 4'h0;
      prev_q  <= 4'h0;
    end else begin
      sync1_q <= {card_io_in, cs_n, card2_present, card1_present};
      sync2_q <= sync1_q;
      prev_q  <= sync2_q;
    end
  end
  wire cs_n_s    = sync2_q[2];
  wire io_in_s   = sync2_q[3];
  wire pres1_chg = sync2_q[0] ^ prev_q[0];
  wire pres2_chg = sync2_q[1] ^ prev_q[1];
  wire reselect  = prev_q[2] & ~cs_n_s;

  reg [1:0] aux_s_q;
  reg       aux_prev_q;
  always @(posedge clk) begin
    if (rst) begin
      aux_s_q    <= 2'h0;
      aux_prev_q <= 1'b0;
    end else begin
      aux_s_q    <= {aux_s_q[0], aux_interrupt_pin};
      aux_prev_q <= aux_s_q[1];
    end
  end
  wire aux_change = aux_s_q[1] ^ aux_prev_q;

  // --------------------------------------------------------------------------
  // Bus decode
  // --------------------------------------------------------------------------
  // Unmapped addresses read zero and drop writes
  wire wr_cfg  = wr && addr == `ADDR_CONFIG_TWO;
  wire rd_hsr  = rd && addr == `ADDR_HW_STATUS;
  wire rd_usr  = rd && addr == `ADDR_UART_STATUS;
  wire wr_sel  = wr && addr == `ADDR_CARD_SELECT;

  // --------------------------------------------------------------------------
  // Per-slot configuration storage
  // --------------------------------------------------------------------------
  wire [7:0] cfg_rd;
  reg  [7:0] cfg_q;
  card_config_store u_store (
    .clk     (clk),
    .rst     (rst),
    .wr_en   (wr_cfg),
    .wr_slot (card_select),
    .wr_data (wdata),
    .rd_slot (card_select),
    .rd_data (cfg_rd)
  );

  // Live copy of the selected slot
  // Store read lags a write by one cycle: hold the copy then, or a stale
  // power-down bit would look like a clear and wake at once
  reg        wr_cfg_q;
  always @(posedge clk) begin
    if (rst) begin
      cfg_q    <= `CONFIG_TWO_RESET;
      wr_cfg_q <= 1'b0;
    end else begin
      wr_cfg_q <= wr_cfg;
      if (wr_cfg) begin
        cfg_q <= wdata & `CONFIG_WRITE_MASK;
      end else if (!wr_cfg_q) begin
        cfg_q <= cfg_rd;
      end
    end
  end

  wire buf_irq_dis = cfg_q[`BIT_BUF_IRQ_DIS];
  wire aux_irq_dis = cfg_q[`BIT_AUX_IRQ_DIS];
  wire pd_bit      = cfg_q[`BIT_POWER_DOWN];
  wire sync_card   = cfg_q[`BIT_SYNC_CARD];

  // --------------------------------------------------------------------------
  // Other registers
  // --------------------------------------------------------------------------
  reg [7:0] clock_cfg_q;
  reg [7:0] rx_q;
  reg [7:0] tx_q;
  reg [7:0] etu_div_q;
  reg       pdown_q;
  always @(posedge clk) begin
    if (rst) begin
      card_select <= 2'h0;
      clock_cfg_q <= 8'h00;
      tx_q        <= 8'h00;
      etu_div_q   <= 8'h00;
    end else if (wr) begin
      // Refused while powered down unless same slot; slot 3 does not exist
      if (wr_sel && (!pdown_q || wdata[1:0] == card_select) &&
          wdata[1:0] < `NUM_CARDS) begin
        card_select <= wdata[1:0];
      end
      if (addr == `ADDR_CLOCK_CONFIG) clock_cfg_q <= wdata;
      if (addr == `ADDR_TX_DATA)      tx_q        <= wdata;
      if (addr == `ADDR_ETU_DIVIDER)  etu_div_q   <= wdata;
    end
  end

  always @(posedge clk) begin
    if (rst) begin
      rx_q <= 8'h00;
    end else if (sync_card) begin
      rx_q <= {7'h00, io_in_s};
    end
  end

  // --------------------------------------------------------------------------
  // Status and power-down
  // --------------------------------------------------------------------------
  reg [3:0] hsr_q;
  reg       buf_ev_q;
  reg       wake_irq_q;
  reg [22:0] wait_q;
  reg       pd_bit_prev_q;
  // Entry needs a fresh 0->1 edge of the bit: a set blocked by the supervisor
  // latch must be cleared and set again
  wire pd_set   = pd_bit & ~pd_bit_prev_q;
  wire pd_clear = ~pd_bit & pd_bit_prev_q & ~cs_n_s;
  wire wake_ev  = pdown_q & (pres1_chg | pres2_chg | aux_change | reselect | pd_clear);

  always @(posedge clk) begin
    if (rst) begin
      hsr_q         <= 4'h0;
      pdown_q       <= 1'b0;
      pd_bit_prev_q <= 1'b0;
    end else begin
      pd_bit_prev_q <= pd_bit;
      if (wake_ev && reselect) begin
        hsr_q <= 4'h0;
      end else begin
        // Set beats the read-clear
        hsr_q[`HSR_AUX_LATCH] <= aux_change | (hsr_q[`HSR_AUX_LATCH] & ~rd_hsr);
        hsr_q[`HSR_SUP_LATCH] <= supervisor_event | (hsr_q[`HSR_SUP_LATCH] & ~rd_hsr);
        hsr_q[`HSR_PRES1_CHG] <= pres1_chg | (hsr_q[`HSR_PRES1_CHG] & ~rd_hsr);
        hsr_q[`HSR_PRES2_CHG] <= pres2_chg | (hsr_q[`HSR_PRES2_CHG] & ~rd_hsr);
      end
      if (wake_ev) begin
        pdown_q <= 1'b0;
      end else if (pd_set && !hsr_q[`HSR_SUP_LATCH]) begin
        pdown_q <= 1'b1;
      end
    end
  end

  always @(posedge clk) begin
    if (rst) begin
      buf_ev_q <= 1'b0;
    end else if ((uart_rx_done | uart_tx_done) && !buf_irq_dis) begin
      buf_ev_q <= 1'b1;
    end else if (rd_usr) begin
      buf_ev_q <= 1'b0;
    end
  end

  // Wake interrupt held until wait elapsed and status read
  // A wake taken in the same cycle as a hardware status read raises none
  always @(posedge clk) begin
    if (rst) begin
      wake_irq_q <= 1'b0;
      wait_q     <= 23'h0;
    end else if (wake_ev && !rd_hsr) begin
      wake_irq_q <= 1'b1;
      wait_q     <= WAKE_WAIT[22:0];
    end else if (wake_irq_q) begin
      if (wait_q != 23'h0) begin
        wait_q <= wait_q - 23'h1;
      end else if (rd_hsr || rd_usr) begin
        wake_irq_q <= 1'b0;
      end
    end
  end

  wire aux_irq = hsr_q[`HSR_AUX_LATCH] & ~aux_irq_dis;
  wire hw_irq  = hsr_q[`HSR_PRES1_CHG] | hsr_q[`HSR_PRES2_CHG] | hsr_q[`HSR_SUP_LATCH];
  assign irq_n = ~(wake_irq_q | aux_irq | hw_irq | buf_ev_q | (|uart_flags[7:1]));

  assign osc_enable = ~pdown_q;

  // --------------------------------------------------------------------------
  // Card I/O, clock and ETU
  // --------------------------------------------------------------------------
  // Open drain in sync mode: drive only a low, release for a one
  assign card_io_out = sync_card ? tx_q[0] : uart_io_out;
  assign card_io_oe  = sync_card ? ~tx_q[0] : uart_io_oe;
  assign card_clk    = sync_card ? clock_cfg_q[`CCR_SYNC_CLOCK] : gen_card_clk;

  // Registered so the data outputs never show a half-updated product
  wire [5:0]  prescale = cfg_q[`BIT_PRESCALE_SEL] ? `PRESCALE_HI : `PRESCALE_LO;
  wire [13:0] etu_full = prescale * etu_div_q;
  wire        halve    = cfg_q[`BIT_ETU_HALVING] & ~clock_cfg_q[`CCR_CLK_IS_XTAL];
  reg  [13:0] etu_q;
  reg         conv_q;
  always @(posedge clk) begin
    if (rst) begin
      etu_q  <= 14'h0000;
      conv_q <= 1'b0;
    end else begin
      etu_q  <= halve ? {1'b0, etu_full[13:1]} : etu_full;
      conv_q <= cfg_q[`BIT_AUTO_CONV_OFF] ? sw_convention : detected_convention;
    end
  end
  assign etu_cycles = etu_q;
  assign convention = conv_q;

  // --------------------------------------------------------------------------
  // Read data
  // --------------------------------------------------------------------------
  always @(posedge clk) begin
    if (rst) begin
      rdata <= 8'h00;
    end else if (rd) begin
      case (addr)
        `ADDR_CONFIG_TWO:   rdata <= cfg_q & `CONFIG_WRITE_MASK;
        `ADDR_CARD_SELECT:  rdata <= {6'h00, card_select};
        `ADDR_HW_STATUS:    rdata <= {4'h0, hsr_q};
        `ADDR_UART_STATUS:  rdata <= {uart_flags[7:1], buffer_empty_full_flag};
        `ADDR_MIXED_STATUS: rdata <= {buffer_empty_full_flag, 6'h00, pdown_q};
        `ADDR_CLOCK_CONFIG: rdata <= clock_cfg_q;
        `ADDR_RX_DATA:      rdata <= rx_q;
        `ADDR_TX_DATA:      rdata <= tx_q;
        `ADDR_ETU_DIVIDER:  rdata <= etu_div_q;
        default:            rdata <= 8'h00;
      endcase
    end else begin
      rdata <= 8'h00;
    end
  end

endmodule
`default_nettype wire

/* File: verification/cfg2_asserts.sv */
// Concurrent checks on the card configuration block ports
`timescale 1ns/1ps
`default_nettype none
`include "card_uart_config_two_defines.vh"
module cfg2_chk #(
  parameter WAKE_WAIT = 20
) (
  input wire       clk,
  input wire       rst,
  input wire [3:0] addr,
  input wire [7:0] wdata,
  input wire       wr,
  input wire       rd,
  input wire [7:0] rdata,
  input wire       osc_enable,
  input wire       irq_n,
  input wire [1:0] card_select,
  input wire       buffer_empty_full_flag,
  input wire       card1_present,
  input wire       card2_present,
  input wire       aux_interrupt_pin
);
  default clocking @(posedge clk); endclocking
  default disable iff (rst);
  // ---------------------------------------------------------------------------
  // Wake tracking
  // ---------------------------------------------------------------------------
  logic [31:0] since_q;
  logic        osc_q;
  logic        hsr_rd_q;
  always @(posedge clk) begin
    osc_q    <= osc_enable;
    hsr_rd_q <= rd && addr == `ADDR_HW_STATUS;
    if (rst)
      since_q <= WAKE_WAIT;
    else if (osc_enable && !osc_q && !hsr_rd_q)
      since_q <= 32'h0;
    else if (since_q < WAKE_WAIT)
      since_q <= since_q + 32'h1;
  end
  sequence s_wake;
    $rose(osc_enable) && !$past(rd && addr == `ADDR_HW_STATUS);
  endsequence
  sequence s_pin_event;
    ($changed(card1_present) || $changed(card2_present) || $changed(aux_interrupt_pin))
      && !osc_enable;
  endsequence
  property p_reset;
    disable iff (1'b0) rst |=> rdata == 8'h00 && irq_n && osc_enable && card_select == 2'h0;
  endproperty
  a_reset: assert property (p_reset) else $error("reset state wrong");
  property p_top_zero;
    rd && addr == `ADDR_CONFIG_TWO |=> rdata[7] == 1'b0;
  endproperty
  a_top_zero: assert property (p_top_zero) else $error("top bit not zero");
  property p_mirror;
    rd && addr == `ADDR_MIXED_STATUS && $stable(buffer_empty_full_flag)
      |=> rdata[7] == $past(buffer_empty_full_flag);
  endproperty
  a_mirror: assert property (p_mirror) else $error("flag copy wrong");
  property p_stop;
    $fell(osc_enable) |-> $past(wr && addr == `ADDR_CONFIG_TWO && wdata[4], 2);
  endproperty
  a_stop: assert property (p_stop) else $error("oscillator stop without write");
  property p_no_reselect;
    $changed(card_select) |-> $past(osc_enable);
  endproperty
  a_no_reselect: assert property (p_no_reselect) else $error("select in power-down");
  property p_pin_wake;
    s_pin_event |-> ##[1:6] osc_enable;
  endproperty
  a_pin_wake: assert property (p_pin_wake) else $error("no wake on pin event");
  property p_wake_irq;
    s_wake |-> !irq_n;
  endproperty
  a_wake_irq: assert property (p_wake_irq) else $error("no wake interrupt");
  property p_wake_hold;
    since_q < WAKE_WAIT - 1 |-> !irq_n;
  endproperty
  a_wake_hold: assert property (p_wake_hold) else $error("wake interrupt too short");
endmodule
bind card_uart_config_two cfg2_chk #(.WAKE_WAIT(WAKE_WAIT)) chk (
  .clk(clk), .rst(rst), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata),
  .osc_enable(osc_enable), .irq_n(irq_n), .card_select(card_select),
  .buffer_empty_full_flag(buffer_empty_full_flag), .card1_present(card1_present),
  .card2_present(card2_present), .aux_interrupt_pin(aux_interrupt_pin)
);
`default_nettype wire

/* File: verification/card_model.sv */
// Card side: open-drain I/O with pull-up and presence switches
`timescale 1ns/1ps
`default_nettype none
module card_model (
  input  wire logic card_io_out,
  input  wire logic card_io_oe,
  input  wire logic pull_low,
  input  wire logic ins1,
  input  wire logic ins2,
  output wire logic card_io_in,
  output wire logic card1_present,
  output wire logic card2_present
);
  // Wired-and, released line floats to the pull-up level
  assign card_io_in    = (card_io_oe ? card_io_out : 1'b1) & ~pull_low;
  assign card1_present = ins1;
  assign card2_present = ins2;
endmodule
`default_nettype wire

/* File: verification/card_uart_config_two_tb.sv */
// Self-checking bench for the card configuration block
`timescale 1ns/1ps
`default_nettype none
module card_uart_config_two_tb;
  logic        clk = 0, rst = 1, wr = 0, rd = 0, cs_n = 0, aux = 0, sup = 0, rxd = 0;
  logic        txd = 0, bef = 1, uio = 0, uoe = 1, dconv = 0, sconv = 1, gclk = 1;
  logic        low = 0, ins1 = 0, ins2 = 0;
  logic [3:0]  addr = 4'h0;
  logic [7:0]  wdata = 8'h00;
  wire  [7:0]  rdata;
  wire         cin, cout, coe, cclk, osc, irq_n, conv, p1, p2;
  wire  [1:0]  sel;
  wire  [13:0] etu;
  int          err_total = 0, checks = 0;
  always #4 clk = ~clk;
  card_model cm (.card_io_out(cout), .card_io_oe(coe), .pull_low(low), .ins1(ins1),
    .ins2(ins2), .card_io_in(cin), .card1_present(p1), .card2_present(p2));
  card_uart_config_two #(.WAKE_WAIT(20)) dut (.clk(clk), .rst(rst), .addr(addr),
    .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata), .cs_n(cs_n), .aux_interrupt_pin(aux),
    .card1_present(p1), .card2_present(p2), .supervisor_event(sup), .uart_rx_done(rxd),
    .uart_tx_done(txd), .buffer_empty_full_flag(bef), .uart_flags(8'h00),
    .uart_io_out(uio), .uart_io_oe(uoe), .detected_convention(dconv),
    .sw_convention(sconv), .gen_card_clk(gclk), .card_io_in(cin), .card_io_out(cout),
    .card_io_oe(coe), .card_clk(cclk), .osc_enable(osc), .irq_n(irq_n),
    .card_select(sel), .convention(conv), .etu_cycles(etu));
  // ---------------------------------------------------------------------------
  // Bus and compare helpers
  // ---------------------------------------------------------------------------
  task print_verdict;
    if (err_total == 0 && checks > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask
  task chk(input string n, input logic [13:0] e, input logic [13:0] g);
    checks++;
    if (g !== e) begin
      err_total++;
      $display("CHECK FAILED %s expected %h seen %h", n, e, g);
    end
  endtask
  task w(input logic [3:0] a, input logic [7:0] d);
    @(posedge clk) begin addr <= a; wdata <= d; wr <= 1'b1; end
    @(posedge clk) wr <= 1'b0;
  endtask
  task r(input logic [3:0] a, input logic [7:0] e);
    @(posedge clk) begin addr <= a; rd <= 1'b1; end
    @(posedge clk) rd <= 1'b0;
    #1 chk("rdata", {6'h00, e}, {6'h00, rdata});
  endtask
  task settle(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask
  // Bounded: a wake that never comes ends the run
  task wake_wait;
    for (int i = 0; i < 12 && osc !== 1'b1; i++) begin
      @(posedge clk);
      #1;
    end
    #1 chk("osc_enable", 14'h1, osc);
    if (osc !== 1'b1) print_verdict();
  endtask
  task ce(input logic [7:0] d, input logic [13:0] e, input logic c);
    w(4'h0, d);
    settle(1);
    chk("etu_cycles", e, etu);
    chk("convention", c, conv);
  endtask
  // ---------------------------------------------------------------------------
  // Scenarios
  // ---------------------------------------------------------------------------
  task t_reset_aux;
    r(4'h0, 8'h00);
    r(4'hF, 8'h00);
    r(4'h4, 8'h80);
    w(4'h0, 8'h20);
    @(posedge clk) aux <= 1'b1;
    settle(5);
    chk("irq_n", 14'h1, irq_n);
    r(4'h2, 8'h01);
    w(4'h0, 8'h00);
    settle(1);
    chk("irq_n", 14'h1, irq_n);
    w(4'h0, 8'h20);
  endtask
  task t_slots;
    w(4'h1, 8'h01);
    settle(2);
    w(4'h0, 8'hAD);
    r(4'h0, 8'h2D);
    w(4'h1, 8'h03);
    settle(2);
    chk("card_select", 14'h1, sel);
    w(4'h1, 8'h00);
    settle(2);
    r(4'h0, 8'h20);
  endtask
  task t_buffer;
    w(4'h0, 8'h60);
    @(posedge clk) txd <= 1'b1;
    @(posedge clk) txd <= 1'b0;
    settle(2);
    chk("irq_n", 14'h1, irq_n);
    r(4'h3, 8'h01);
    w(4'h0, 8'h20);
    @(posedge clk) rxd <= 1'b1;
    @(posedge clk) rxd <= 1'b0;
    settle(2);
    chk("irq_n", 14'h0, irq_n);
    r(4'h3, 8'h01);
    chk("irq_n", 14'h1, irq_n);
  endtask
  task t_etu;
    w(4'h8, 8'h04);
    ce(8'h21, 14'h0080, 1'b0);
    ce(8'h24, 14'h007C, 1'b1);
    ce(8'h22, 14'h003E, 1'b0);
    w(4'h5, 8'h02);
    ce(8'h22, 14'h007C, 1'b0);
    w(4'h5, 8'h00);
  endtask
  task t_sync;
    ce(8'h20, 14'h007C, 1'b0);
    chk("card_io", 14'h2, {coe, cout});
    chk("card_clk", 14'h1, cclk);
    w(4'h0, 8'h28);
    w(4'h5, 8'h00);
    settle(1);
    chk("card_clk", 14'h0, cclk);
    w(4'h5, 8'h01);
    w(4'h7, 8'h00);
    settle(1);
    chk("card_clk", 14'h1, cclk);
    chk("card_io", 14'h2, {coe, cout});
    w(4'h7, 8'h01);
    @(posedge clk) low <= 1'b1;
    settle(4);
    chk("card_io_oe", 14'h0, coe);
    r(4'h6, 8'h00);
    @(posedge clk) low <= 1'b0;
    settle(4);
    r(4'h6, 8'h01);
    w(4'h0, 8'h20);
  endtask
  task t_pdown;
    @(posedge clk) sup <= 1'b1;
    @(posedge clk) sup <= 1'b0;
    w(4'h0, 8'h30);
    settle(3);
    chk("osc_enable", 14'h1, osc);
    r(4'h2, 8'h02);
    w(4'h0, 8'h20);
    w(4'h0, 8'h30);
    settle(2);
    chk("osc_enable", 14'h0, osc);
    w(4'h1, 8'h01);
    settle(2);
    chk("card_select", 14'h0, sel);
    @(posedge clk) ins1 <= 1'b1;
    wake_wait();
    chk("irq_n", 14'h0, irq_n);
    settle(22);
    r(4'h2, 8'h04);
    chk("irq_n", 14'h1, irq_n);
    w(4'h0, 8'h20);
  endtask
  task t_reselect;
    w(4'h0, 8'h30);
    settle(2);
    @(posedge clk) cs_n <= 1'b1;
    settle(4);
    @(posedge clk) cs_n <= 1'b0;
    wake_wait();
    chk("irq_n", 14'h0, irq_n);
    settle(22);
    r(4'h2, 8'h00);
    chk("irq_n", 14'h1, irq_n);
    w(4'h0, 8'h20);
    w(4'h0, 8'h30);
    settle(2);
    w(4'h0, 8'h20);
    wake_wait();
  endtask
  task t_hsr_wake;
    settle(22);
    r(4'h2, 8'h00);
    chk("irq_n", 14'h1, irq_n);
    w(4'h0, 8'h30);
    settle(2);
    chk("osc_enable", 14'h0, osc);
    @(posedge clk) ins2 <= 1'b1;
    @(posedge clk);
    r(4'h2, 8'h00);
    chk("osc_enable", 14'h1, osc);
    r(4'h2, 8'h08);
    chk("irq_n", 14'h1, irq_n);
    w(4'h0, 8'h20);
  endtask
  initial begin
    repeat (5) @(posedge clk);
    rst <= 1'b0;
    t_reset_aux();
    t_slots();
    t_buffer();
    t_etu();
    t_sync();
    t_pdown();
    t_reselect();
    t_hsr_wake();
    print_verdict();
  end
  initial begin
    #400000;
    err_total++;
    print_verdict();
  end
endmodule
`default_nettype wire
